// [hw/ism_pkg.sv]
package ism_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ISM_OFF_CONTROL = 3'h0;
  localparam logic [2:0] ISM_OFF_STATUS = 3'h1;
  localparam logic [2:0] ISM_OFF_OWNADDR = 3'h2;
  localparam logic [2:0] ISM_OFF_BUFFER = 3'h3;
  localparam logic [2:0] ISM_OFF_IRQ_STAT = 3'h4;
  localparam logic [2:0] ISM_OFF_IRQ_MASK = 3'h5;
  // reset values
  localparam logic [7:0] ISM_RST_CONTROL = 8'h00;
  localparam logic [7:0] ISM_RST_STATUS = 8'h00;
  localparam logic [7:0] ISM_RST_MASK = 8'hFF;
  localparam logic [7:0] ISM_RST_OWNADDR = 8'h00;
  // control fields
  localparam int ISM_CTL_EN = 5;
  localparam int ISM_CTL_REL = 4;
  // status fields
  localparam int ISM_ST_SLEW = 7;
  localparam int ISM_ST_EDGE = 6;
  localparam int ISM_ST_DATA = 5;
  localparam int ISM_ST_STOP = 4;
  localparam int ISM_ST_START = 3;
  localparam int ISM_ST_RW = 2;
  localparam int ISM_ST_UA = 1;
  localparam int ISM_ST_BF = 0;
  // interrupt status bits
  localparam int ISM_IRQ_START = 0;
  localparam int ISM_IRQ_STOP = 1;
  localparam int ISM_IRQ_BYTE = 2;
  localparam int ISM_IRQ_UA = 3;
  localparam int ISM_IRQ_W = 4;
  // mode codes
  localparam logic [3:0] ISM_MODE_7BIT = 4'h6;
  localparam logic [3:0] ISM_MODE_10BIT = 4'h7;
  localparam logic [3:0] ISM_MODE_MSKLD = 4'h9;
  localparam logic [3:0] ISM_MODE_FWM = 4'hB;
  localparam logic [3:0] ISM_MODE_7BIT_SP = 4'hE;
  localparam logic [3:0] ISM_MODE_10BIT_SP = 4'hF;
  localparam logic [3:0] ISM_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ISM_ACK_BIT = 4'h9;
  localparam logic [4:0] ISM_TENBIT_HDR = 5'h1E;

  typedef enum logic [2:0] {
    ISM_IDLE,
    ISM_ADDR1,
    ISM_ADDR2,
    ISM_RESTART,
    ISM_DATA,
    ISM_IGNORE
  } ism_phase_t;
endpackage

// [hw/ism_top.sv]
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
module ism_top
  import ism_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SCL_O,
  output logic SCL_OE_O,
  output logic SDA_O,
  output logic SDA_OE_O,
  output logic SLEW_LIMIT_O,
  output logic IRQ_O
);

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;
    logic [7:0] control;
    logic [7:0] status;
    logic [7:0] mask;
    logic [7:0] own_addr;
    logic [7:0] buffer;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    ism_phase_t phase;
    logic matched;
    logic tx;
    logic ack_drive;
    logic scl_hold;
    logic [4:0] irq_stat;
    logic [4:0] irq_mask;
    logic [7:0] rdata;
    logic scl_oe;
    logic sda_oe;
    logic slew_lim;
    logic irq;
  } ism_state_t;

  ism_state_t s_reg;
  ism_state_t s_next;

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic enabled;
  logic [3:0] mode;
  logic ten_bit;
  logic mask_load;
  logic slave_on;
  logic [7:0] rx_byte;
  logic [7:0] cmp_mask;
  logic addr_hit;
  logic [4:0] irq_set;
  logic [7:0] ev_clr;

  assign scl_s = s_reg.scl_sync[1];
  assign sda_s = s_reg.sda_sync[1];
  assign scl_rise = scl_s & ~s_reg.scl_d;
  assign scl_fall = ~scl_s & s_reg.scl_d;
  assign start_ev = scl_s & s_reg.scl_d & s_reg.sda_d & ~sda_s;
  assign stop_ev = scl_s & s_reg.scl_d & ~s_reg.sda_d & sda_s;
  assign enabled = s_reg.control[ISM_CTL_EN];
  assign mode = s_reg.control[3:0];
  assign ten_bit = (mode == ISM_MODE_10BIT) | (mode == ISM_MODE_10BIT_SP);
  assign mask_load = (mode == ISM_MODE_MSKLD);
  // firmware master and reserved codes leave the slave idle
  assign slave_on = enabled & ((mode == ISM_MODE_7BIT) | ten_bit |
                    (mode == ISM_MODE_7BIT_SP));
  assign rx_byte = {s_reg.shreg[6:0], sda_s};

  // per-bit compare mask; bit zero only counts in ten-bit mode
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_mask
      if (gi == 0) begin : g_b0
        assign cmp_mask[gi] = s_reg.mask[gi] & ten_bit;
      end else begin : g_bn
        assign cmp_mask[gi] = s_reg.mask[gi];
      end
    end
  endgenerate

  always_comb begin
    addr_hit = 1'b0;
    case (s_reg.phase)
      // judged at the eighth fall, when the shift register holds the byte
      ISM_ADDR1: begin
        if (ten_bit) begin
          addr_hit = s_reg.shreg[7:3] == ISM_TENBIT_HDR &&
            ((s_reg.shreg[2:0] ^ s_reg.own_addr[2:0]) &
            cmp_mask[2:0]) == 3'h0;
        end else begin
          addr_hit = ((s_reg.shreg[7:1] ^ s_reg.own_addr[7:1]) &
            cmp_mask[7:1]) == 7'h00;
        end
      end
      ISM_ADDR2: begin
        addr_hit = ((s_reg.shreg ^ s_reg.own_addr) & cmp_mask) == 8'h00;
      end
      ISM_RESTART: begin
        addr_hit = s_reg.shreg[7:3] == ISM_TENBIT_HDR;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always_comb begin
    s_next = s_reg;
    irq_set = 5'h00;
    ev_clr = 8'h00;
    s_next.scl_sync = {s_reg.scl_sync[0], SCL_I};
    s_next.sda_sync = {s_reg.sda_sync[0], SDA_I};
    s_next.scl_d = scl_s;
    s_next.sda_d = sda_s;
    s_next.rdata = 8'h00;

    if (RD_I) begin
      unique case (ADDR_I)
        ISM_OFF_CONTROL: s_next.rdata = s_reg.control;
        ISM_OFF_STATUS: s_next.rdata = s_reg.status;
        ISM_OFF_OWNADDR: s_next.rdata = mask_load ? s_reg.mask
                                       : s_reg.own_addr;
        ISM_OFF_BUFFER: begin
          s_next.rdata = s_reg.buffer;
          if (!s_reg.tx) begin
            ev_clr[ISM_ST_BF] = 1'b1;
          end
        end
        ISM_OFF_IRQ_STAT: s_next.rdata = {3'h0, s_reg.irq_stat};
        ISM_OFF_IRQ_MASK: s_next.rdata = {3'h0, s_reg.irq_mask};
        default: s_next.rdata = 8'h00;
      endcase
    end

    if (WR_I) begin
      unique case (ADDR_I)
        ISM_OFF_CONTROL: s_next.control = WDATA_I;
        ISM_OFF_STATUS: begin
          s_next.status[ISM_ST_SLEW] = WDATA_I[ISM_ST_SLEW];
          s_next.status[ISM_ST_EDGE] = WDATA_I[ISM_ST_EDGE];
        end
        ISM_OFF_OWNADDR: begin
          if (mask_load) begin
            s_next.mask = WDATA_I;
          end else begin
            s_next.own_addr = WDATA_I;
            ev_clr[ISM_ST_UA] = 1'b1;
            s_next.scl_hold = 1'b0;
          end
        end
        ISM_OFF_BUFFER: begin
          if (s_reg.tx && s_reg.status[ISM_ST_BF]) begin
            irq_set[ISM_IRQ_W] = 1'b1;
          end else begin
            s_next.buffer = WDATA_I;
            if (s_reg.tx) begin
              s_next.shreg = WDATA_I;
              s_next.status[ISM_ST_BF] = 1'b1;
            end
          end
        end
        ISM_OFF_IRQ_STAT: s_next.irq_stat = s_reg.irq_stat & ~WDATA_I[4:0];
        ISM_OFF_IRQ_MASK: s_next.irq_mask = WDATA_I[4:0];
        default: begin
        end
      endcase
    end
    s_next.status = s_next.status & ~ev_clr;

    if (!enabled) begin
      s_next.status[ISM_ST_STOP] = 1'b0;
      s_next.status[ISM_ST_START] = 1'b0;
      s_next.phase = ISM_IDLE;
      s_next.ack_drive = 1'b0;
      s_next.scl_hold = 1'b0;
    end else if (start_ev) begin
      s_next.status[ISM_ST_START] = 1'b1;
      s_next.status[ISM_ST_STOP] = 1'b0;
      s_next.status[ISM_ST_RW] = 1'b0;
      // the start's own scl fall wraps this to zero
      s_next.bitcnt = '1;
      s_next.ack_drive = 1'b0;
      s_next.phase = (s_reg.matched && ten_bit) ? ISM_RESTART : ISM_ADDR1;
      s_next.tx = 1'b0;
      irq_set[ISM_IRQ_START] = 1'b1;
    end else if (stop_ev) begin
      s_next.status[ISM_ST_STOP] = 1'b1;
      s_next.status[ISM_ST_START] = 1'b0;
      s_next.status[ISM_ST_RW] = 1'b0;
      s_next.phase = ISM_IDLE;
      s_next.matched = 1'b0;
      s_next.ack_drive = 1'b0;
      s_next.tx = 1'b0;
      irq_set[ISM_IRQ_STOP] = 1'b1;
    end else if (slave_on && s_reg.phase != ISM_IDLE) begin
      if (scl_rise && s_reg.bitcnt < ISM_BITS_PER_BYTE && !s_reg.tx) begin
        s_next.shreg = rx_byte;
      end
      if (scl_fall) begin
        s_next.bitcnt = s_reg.bitcnt + 4'h1;
        if (s_reg.tx && s_reg.bitcnt < ISM_BITS_PER_BYTE) begin
          s_next.shreg = {s_reg.shreg[6:0], 1'b0};
        end
        if (s_reg.bitcnt == ISM_BITS_PER_BYTE - 4'h1) begin
          if (s_reg.tx) begin
            s_next.status[ISM_ST_BF] = 1'b0;
            s_next.ack_drive = 1'b0;
          end else if (s_reg.phase == ISM_DATA) begin
            s_next.buffer = s_reg.shreg;
            s_next.status[ISM_ST_BF] = 1'b1;
            s_next.status[ISM_ST_DATA] = 1'b1;
            s_next.ack_drive = 1'b1;
          end else if (addr_hit) begin
            s_next.buffer = s_reg.shreg;
            s_next.status[ISM_ST_BF] = 1'b1;
            s_next.status[ISM_ST_DATA] = 1'b0;
            s_next.ack_drive = 1'b1;
          end else begin
            s_next.phase = ISM_IGNORE;
          end
        end
        if (s_reg.bitcnt == ISM_BITS_PER_BYTE) begin
          s_next.ack_drive = 1'b0;
          s_next.status[ISM_ST_RW] = 1'b0;
          irq_set[ISM_IRQ_BYTE] = s_reg.phase != ISM_IGNORE;
          s_next.bitcnt = 4'h0;
          unique case (s_reg.phase)
            ISM_ADDR1: begin
              s_next.matched = 1'b1;
              if (ten_bit) begin
                s_next.phase = ISM_ADDR2;
                s_next.status[ISM_ST_UA] = 1'b1;
                s_next.scl_hold = 1'b1;
                irq_set[ISM_IRQ_UA] = 1'b1;
              end else begin
                s_next.phase = ISM_DATA;
                s_next.tx = s_reg.buffer[0];
                s_next.status[ISM_ST_RW] = s_reg.buffer[0];
                s_next.status[ISM_ST_BF] = s_reg.status[ISM_ST_BF] &
                  ~s_reg.buffer[0];
                s_next.scl_hold = s_reg.buffer[0];
                s_next.control[ISM_CTL_REL] = ~s_reg.buffer[0];
              end
            end
            ISM_ADDR2: begin
              s_next.phase = ISM_DATA;
              s_next.status[ISM_ST_UA] = 1'b1;
              s_next.scl_hold = 1'b1;
              irq_set[ISM_IRQ_UA] = 1'b1;
            end
            ISM_RESTART: begin
              s_next.phase = ISM_DATA;
              s_next.tx = s_reg.buffer[0];
              s_next.status[ISM_ST_RW] = s_reg.buffer[0];
              s_next.status[ISM_ST_BF] = s_reg.status[ISM_ST_BF] &
                ~s_reg.buffer[0];
            end
            ISM_DATA: begin
              if (s_reg.tx && sda_s) begin
                s_next.phase = ISM_IGNORE;
              end
            end
            default: begin
            end
          endcase
        end
      end
    end
    if (!ten_bit) begin
      s_next.status[ISM_ST_UA] = 1'b0;
    end
    // ack bit resets the counter before nine so ISM_ACK_BIT bounds it
    if (s_next.bitcnt >= ISM_ACK_BIT && s_next.bitcnt != '1) begin
      s_next.bitcnt = 4'h0;
    end

    // transmit output: msb first, or ack low
    s_next.sda_oe = s_next.ack_drive |
      (s_next.tx && s_next.bitcnt < ISM_BITS_PER_BYTE &&
       s_next.phase == ISM_DATA && !s_next.shreg[7]);
    // stretch only once scl is seen low, so the high time is never cut
    s_next.scl_oe = enabled && !scl_s &&
      (s_next.scl_hold || (s_next.tx && !s_next.control[ISM_CTL_REL]));
    if (s_reg.scl_hold && s_next.control[ISM_CTL_REL] && !ten_bit) begin
      s_next.scl_hold = 1'b0;
    end
    s_next.slew_lim = ~s_next.status[ISM_ST_SLEW];

    s_next.irq_stat = s_next.irq_stat | irq_set;
    s_next.irq = |(s_next.irq_stat & s_next.irq_mask);
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      s_reg <= '0;
      s_reg.scl_sync <= 2'h3;
      s_reg.sda_sync <= 2'h3;
      s_reg.scl_d <= 1'b1;
      s_reg.sda_d <= 1'b1;
      s_reg.control <= ISM_RST_CONTROL;
      s_reg.status <= ISM_RST_STATUS;
      s_reg.mask <= ISM_RST_MASK;
      s_reg.own_addr <= ISM_RST_OWNADDR;
      s_reg.phase <= ISM_IDLE;
      s_reg.slew_lim <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign RDATA_O = s_reg.rdata;
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE_O = s_reg.scl_oe;
  assign SDA_OE_O = s_reg.sda_oe;
  assign SLEW_LIMIT_O = s_reg.slew_lim;
  assign IRQ_O = s_reg.irq;

endmodule // ism_top

// [sim/ism_master.sv]
`timescale 1ns/1ns
module ism_master (
  input wire logic clk_i,
  input wire logic scl_oe_i,
  input wire logic sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  logic scl_low = 1'b0;
  logic sda_low = 1'b0;
  // pull-ups on both lines: a released line reads high, never stale
  assign scl_o = !(scl_low || scl_oe_i === 1'b1);
  assign sda_o = !(sda_low || sda_oe_i === 1'b1);
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic start();
    sda_low <= 1'b1;
    tick(4);
    scl_low <= 1'b1;
    tick(1);
  endtask
  // 4 clocks low, 5 high; waits while the slave stretches scl
  task automatic put_bit(input logic b, output logic r);
    sda_low <= !b;
    tick(3);
    scl_low <= 1'b0;
    for (int n = 0; n < 4000 && !scl_o; n++) @(posedge clk_i);
    tick(4);
    r = sda_o;
    scl_low <= 1'b1;
    tick(1);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    tick(3);
    scl_low <= 1'b0;
    tick(4);
    sda_low <= 1'b0;
    tick(4);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(d[i], r);
    put_bit(1'b1, r);
    ack = !r;
  endtask
  task automatic get_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(!ack, r);
  endtask
endmodule // ism_master

// [sim/ism_top_assertions.sv]
`timescale 1ns/1ns
module ism_top_checker
  import ism_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic [2:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic SCL_I,
  input wire logic SDA_I,
  input wire logic SCL_OE_O,
  input wire logic SDA_OE_O,
  input wire logic SLEW_LIMIT_O,
  input wire logic IRQ_O
);
  logic [7:0] ctl_q, own_q, msk_q, imsk_q;
  logic slew_q;
  logic mskld;
  assign mskld = ctl_q[3:0] == ISM_MODE_MSKLD;
  // shadows follow software writes only; hardware updates are not modelled
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ctl_q <= ISM_RST_CONTROL;
      own_q <= ISM_RST_OWNADDR;
      msk_q <= ISM_RST_MASK;
      imsk_q <= 8'h00;
      slew_q <= 1'b0;
    end else if (WR_I) begin
      if (ADDR_I == ISM_OFF_CONTROL) ctl_q <= WDATA_I;
      if (ADDR_I == ISM_OFF_IRQ_MASK) imsk_q <= WDATA_I;
      if (ADDR_I == ISM_OFF_STATUS) slew_q <= WDATA_I[ISM_ST_SLEW];
      if (ADDR_I == ISM_OFF_OWNADDR && mskld) msk_q <= WDATA_I;
      if (ADDR_I == ISM_OFF_OWNADDR && !mskld) own_q <= WDATA_I;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  chk_read_quiet: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data outside its slot");
  chk_own_mux:
  assert property (RD_I && ADDR_I == ISM_OFF_OWNADDR
    |=> RDATA_O == (mskld ? msk_q : own_q)) else $error("address read");
  chk_slew_pin:
  assert property (SLEW_LIMIT_O == !slew_q) else $error("slew pin");
  chk_start_stop_excl:
  assert property (RD_I && ADDR_I == ISM_OFF_STATUS
    |=> !(RDATA_O[ISM_ST_STOP] && RDATA_O[ISM_ST_START]))
    else $error("start and stop both set");
  chk_ua_seven:
  assert property (RD_I && ADDR_I == ISM_OFF_STATUS
    && ctl_q[3:0] != ISM_MODE_10BIT && ctl_q[3:0] != ISM_MODE_10BIT_SP
    |=> !RDATA_O[ISM_ST_UA]) else $error("update flag outside ten-bit");
  chk_off_no_drive:
  assert property (!ctl_q[ISM_CTL_EN] && !$past(ctl_q[ISM_CTL_EN])
    |-> !SDA_OE_O && !SCL_OE_O) else $error("drive while disabled");
  chk_start_irq:
  assert property (ctl_q == 8'h3E && imsk_q[ISM_IRQ_START] && SCL_I
    && $past(SCL_I) && $fell(SDA_I) |-> ##[1:8] IRQ_O)
    else $error("start not flagged");
  chk_stop_irq:
  assert property (ctl_q == 8'h3E && imsk_q[ISM_IRQ_STOP] && SCL_I
    && $past(SCL_I) && $rose(SDA_I) |-> ##[1:8] IRQ_O)
    else $error("stop not flagged");
  chk_irq_masked:
  assert property (imsk_q == 8'h00 && $past(imsk_q) == 8'h00 |-> !IRQ_O)
    else $error("masked interrupt");
  cov_mask_read: cover property (RD_I && ADDR_I == ISM_OFF_OWNADDR && mskld);
  cov_stretch: cover property ($rose(SCL_OE_O));
  cov_irq: cover property ($rose(IRQ_O));
endmodule // ism_top_checker
bind ism_top ism_top_checker chk_u (.CLK_I(CLK_I), .SRST_I(SRST_I),
  .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
  .RDATA_O(RDATA_O), .SCL_I(SCL_I), .SDA_I(SDA_I), .SCL_OE_O(SCL_OE_O),
  .SDA_OE_O(SDA_OE_O), .SLEW_LIMIT_O(SLEW_LIMIT_O), .IRQ_O(IRQ_O));

// [sim/ism_top_bench.sv]
`timescale 1ns/1ns
module ism_top_bench
  import ism_pkg::*;
;
  logic CLK_I, SRST_I, WR_I, RD_I, SCL_I, SDA_I;
  logic SCL_OE_O, SDA_OE_O, SLEW_LIMIT_O, IRQ_O;
  logic [2:0] ADDR_I;
  logic [7:0] WDATA_I, RDATA_O, own, msk, a, d, rx;
  logic ack;
  int miscompares = 0;
  int tests_run = 0;
  ism_top dut_u (.CLK_I(CLK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .SCL_I(SCL_I), .SDA_I(SDA_I), .SCL_O(), .SCL_OE_O(SCL_OE_O),
    .SDA_O(), .SDA_OE_O(SDA_OE_O), .SLEW_LIMIT_O(SLEW_LIMIT_O),
    .IRQ_O(IRQ_O));
  ism_master mst_u (.clk_i(CLK_I), .scl_oe_i(SCL_OE_O),
    .sda_oe_i(SDA_OE_O), .scl_o(SCL_I), .sda_o(SDA_I));
  initial begin
    CLK_I = 1'b0;
    forever #10 CLK_I = ~CLK_I;
  end
  function automatic logic hit(input logic [7:0] x, o, m);
    return ((x ^ o) & m & 8'hFE) == 8'h00;
  endfunction
  task automatic end_of_test();
    $display("miscompares=%0d tests_run=%0d", miscompares, tests_run);
    if (miscompares == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, exp, input string m);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // a gap edge after each strobe keeps one assignment per time step
  task automatic wr(input logic [2:0] ad, input logic [7:0] wd);
    ADDR_I <= ad;
    WDATA_I <= wd;
    WR_I <= 1'b1;
    @(posedge CLK_I);
    WR_I <= 1'b0;
    @(posedge CLK_I);
  endtask
  task automatic rchk(input logic [2:0] ad, input logic [7:0] m, e,
    input string s);
    ADDR_I <= ad;
    RD_I <= 1'b1;
    @(posedge CLK_I);
    RD_I <= 1'b0;
    @(posedge CLK_I);
    chk(RDATA_O & m, e, s);
  endtask
  initial begin
    SRST_I = 1'b1;
    WR_I = 1'b0;
    RD_I = 1'b0;
    ADDR_I = 3'h0;
    WDATA_I = 8'h00;
    void'($urandom(32'h019f55d2));
    repeat (8) @(posedge CLK_I);
    SRST_I <= 1'b0;
    @(posedge CLK_I);
    rchk(ISM_OFF_CONTROL, 8'hFF, ISM_RST_CONTROL, "ctl rst");
    rchk(ISM_OFF_STATUS, 8'hFF, ISM_RST_STATUS, "st rst");
    rchk(ISM_OFF_OWNADDR, 8'hFF, ISM_RST_OWNADDR, "own rst");
    wr(3'h7, 8'hFF);
    rchk(3'h7, 8'hFF, 8'h00, "unmapped");
    wr(ISM_OFF_CONTROL, {4'h2, ISM_MODE_MSKLD});
    rchk(ISM_OFF_OWNADDR, 8'hFF, ISM_RST_MASK, "mask rst");
    msk = 8'($urandom) | 8'h01;
    own = 8'($urandom) | 8'h01;
    wr(ISM_OFF_OWNADDR, msk);
    rchk(ISM_OFF_OWNADDR, 8'hFF, msk, "mask");
    wr(ISM_OFF_CONTROL, 8'h3E);
    rchk(ISM_OFF_OWNADDR, 8'hFF, 8'h00, "own kept");
    wr(ISM_OFF_OWNADDR, own);
    rchk(ISM_OFF_OWNADDR, 8'hFF, own, "own");
    for (int s = 1; s >= 0; s--) begin
      wr(ISM_OFF_STATUS, {s[0], 7'h00});
      @(posedge CLK_I);
      chk({7'h0, SLEW_LIMIT_O}, {7'h0, !s[0]}, "slew pin");
      rchk(ISM_OFF_STATUS, 8'h80, {s[0], 7'h00}, "slew");
    end
    wr(ISM_OFF_IRQ_MASK, 8'h1F);
    for (int i = 0; i < 8; i++) begin
      a = 8'($urandom) & 8'hFE;
      if (i[0]) a = ((own & msk) | (a & ~msk)) & 8'hFE;
      mst_u.start();
      mst_u.put_byte(a, ack);
      chk({7'h0, ack}, {7'h0, hit(a, own, msk)}, "ack");
      if (hit(a, own, msk)) begin
        rchk(ISM_OFF_STATUS, 8'h3C, 8'h08, "addr st");
        d = 8'($urandom);
        mst_u.put_byte(d, ack);
        rchk(ISM_OFF_STATUS, 8'h39, 8'h29, "data st");
        rchk(ISM_OFF_BUFFER, 8'hFF, d, "rx");
        rchk(ISM_OFF_STATUS, 8'h01, 8'h00, "bf clr");
      end
      mst_u.stop();
      rchk(ISM_OFF_STATUS, 8'h18, 8'h10, "stop st");
      chk({7'h0, IRQ_O}, 8'h01, "irq set");
      wr(ISM_OFF_IRQ_MASK, 8'h00);
      @(posedge CLK_I);
      chk({7'h0, IRQ_O}, 8'h00, "irq masked");
      wr(ISM_OFF_IRQ_MASK, 8'h1F);
      wr(ISM_OFF_IRQ_STAT, 8'h1F);
      @(posedge CLK_I);
      chk({7'h0, IRQ_O}, 8'h00, "irq clr");
    end
    mst_u.start();
    mst_u.put_byte(own, ack);
    chk({7'h0, ack}, 8'h01, "rd ack");
    // the ninth fall reaches the status a few clocks after the pin
    repeat (2) @(posedge CLK_I);
    rchk(ISM_OFF_STATUS, 8'h04, 8'h04, "rw");
    d = 8'($urandom);
    fork
      mst_u.get_byte(1'b0, rx);
      begin
        repeat (20) @(posedge CLK_I);
        chk({7'h0, SCL_OE_O}, 8'h01, "scl held");
        wr(ISM_OFF_BUFFER, d);
        rchk(ISM_OFF_STATUS, 8'h01, 8'h01, "tx bf");
        wr(ISM_OFF_CONTROL, 8'h3E);
      end
    join
    chk(rx, d, "tx");
    rchk(ISM_OFF_STATUS, 8'h01, 8'h00, "tx done");
    mst_u.stop();
    end_of_test();
  end
  initial begin
    repeat (30000) @(posedge CLK_I);
    miscompares++;
    end_of_test();
  end
endmodule // ism_top_bench
